// ===== rtl/aqp_core.sv
// ADPCM quantizer, inverse quantizer and eight-tap prediction filter.
`timescale 1ns/100ps
`default_nettype none
`include "aqp_regs.svh"
module aqp_core
  import aqp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic [15:0] sample_in,
  input wire logic decode_mode,
  input wire logic [3:0] codeword_in,
  input wire logic [12:0] scale_factor,
  input wire aqp_coef_t coef,
  output logic sample_ready,
  output logic [3:0] codeword_out,
  output logic codeword_valid,
  output logic [15:0] estimate_out,
  output logic [15:0] dq_out,
  output logic [15:0] recon_out,
  output logic done
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] QB [`AQP_NUM_BOUNDS] = '{`AQP_QB0, `AQP_QB1, `AQP_QB2,
    `AQP_QB3, `AQP_QB4, `AQP_QB5, `AQP_QB6};
  localparam logic [23:0] IQ [`AQP_NUM_TAPS] = '{`AQP_IQ0, `AQP_IQ1, `AQP_IQ2,
    `AQP_IQ3, `AQP_IQ4, `AQP_IQ5, `AQP_IQ6, `AQP_IQ7};

  // A zero magnitude keeps an explicit leading one so later products stay sane.
  function automatic aqp_float_t to_float(input logic sgn, input logic [14:0] mag);
    aqp_float_t f;
    logic [3:0] e;
    logic [20:0] sh;
    e = 4'h0;
    for (int i = 0; i < 15; i++)
    begin
      if (mag[i])
      begin
        e = 4'(i + 1);
      end
    end
    sh = {mag, 6'h00} >> e;
    f.sgn = sgn;
    f.exp = e;
    f.mant = (mag == 15'h0000) ? `AQP_ZERO_MANT : sh[5:0];
    return f;
  endfunction

  function automatic logic [15:0] tap_mult(input logic [15:0] cw, input aqp_float_t d);
    logic [15:0] neg;
    logic [12:0] cm;
    aqp_float_t cf;
    logic [4:0] pe;
    logic [11:0] pm_full;
    logic [22:0] wide;
    logic [14:0] mag;
    neg = -cw;
    cm = cw[15] ? neg[14:2] : cw[14:2];
    cf = to_float(cw[15], {2'b00, cm});
    pe = 5'(cf.exp) + 5'(d.exp);
    pm_full = cf.mant * d.mant;
    if (pe > `AQP_PP_EXP_BIAS)
    begin
      wide = {8'h00, pm_full[11:4], 7'h00} << 5'(pe - `AQP_PP_EXP_BIAS);
    end
    else
    begin
      wide = {8'h00, pm_full[11:4], 7'h00} >> 5'(`AQP_PP_EXP_BIAS - pe);
    end
    mag = wide[14:0];
    return (cf.sgn ^ d.sgn) ? -{1'b0, mag} : {1'b0, mag};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  aqp_state_t state_r, state_nxt;
  logic [2:0] tap_r, tap_nxt;
  logic [2:0] dqp_r, dqp_nxt;
  logic srp_r, srp_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [15:0] smp_r, smp_nxt;
  logic [12:0] y_r, y_nxt;
  aqp_coef_t coef_r, coef_nxt;
  logic mode_r, mode_nxt;
  logic [3:0] rx_r, rx_nxt;
  logic neg_r, neg_nxt;
  logic [11:0] dln_r, dln_nxt;
  logic [2:0] q_r, q_nxt;
  logic [11:0] dql_r, dql_nxt;
  logic dqs_r, dqs_nxt;
  logic [14:0] dqm_r, dqm_nxt;
  logic ready_r, ready_nxt;
  logic [3:0] cw_r, cw_nxt;
  logic cwv_r, cwv_nxt;
  logic [15:0] se_r, se_nxt;
  logic [15:0] dq_r, dq_nxt;
  logic [15:0] sr_r, sr_nxt;
  logic done_r, done_nxt;

  logic mem_we;
  logic [2:0] mem_waddr;
  aqp_float_t mem_wdata;
  logic [2:0] mem_raddr;
  logic [10:0] mem_rdata;

  function automatic logic [2:0] tap_addr(input logic [2:0] t, input logic [2:0] dp, input logic sp);
    if (t <= `AQP_LAST_ZERO)
    begin
      return (dp >= t) ? 3'(dp - t) : 3'(dp + 3'h6 - t);
    end
    return {2'b11, sp ^ t[0]};
  endfunction

  aqp_tap_mem #(.DEPTH(`AQP_NUM_TAPS), .AW(3), .W(11)) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata_r(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [15:0] prod;
    logic [15:0] sum;
    logic [16:0] dif;
    logic [16:0] dabs;
    logic [14:0] dm;
    aqp_float_t lf;
    logic [21:0] lsh;
    logic [3:0] le;
    logic [3:0] cwu;
    logic [2:0] idx;
    logic [7:0] am;
    logic [14:0] amag;
    logic [15:0] srn;
    prod = 16'h0000;
    sum = 16'h0000;
    dif = 17'h00000;
    dabs = 17'h00000;
    dm = 15'h0000;
    lf = '0;
    lsh = 22'h000000;
    le = 4'h0;
    cwu = 4'h0;
    idx = 3'h0;
    am = 8'h00;
    amag = 15'h0000;
    srn = 16'h0000;
    state_nxt = state_r;
    tap_nxt = tap_r;
    dqp_nxt = dqp_r;
    srp_nxt = srp_r;
    acc_nxt = acc_r;
    smp_nxt = smp_r;
    y_nxt = y_r;
    coef_nxt = coef_r;
    mode_nxt = mode_r;
    rx_nxt = rx_r;
    neg_nxt = neg_r;
    dln_nxt = dln_r;
    q_nxt = q_r;
    dql_nxt = dql_r;
    dqs_nxt = dqs_r;
    dqm_nxt = dqm_r;
    ready_nxt = 1'b0;
    cw_nxt = cw_r;
    cwv_nxt = 1'b0;
    se_nxt = se_r;
    dq_nxt = dq_r;
    sr_nxt = sr_r;
    done_nxt = 1'b0;
    mem_we = 1'b0;
    mem_waddr = 3'h0;
    mem_wdata = to_float(1'b0, 15'h0000);
    mem_raddr = tap_addr(3'h0, dqp_r, srp_r);
    unique case (state_r)
      ST_INIT:
      begin
        // The delay store has no reset of its own, so it is cleared entry by entry.
        mem_we = 1'b1;
        mem_waddr = tap_r;
        tap_nxt = 3'(tap_r + 3'h1);
        if (tap_r == `AQP_LAST_TAP)
        begin
          state_nxt = ST_IDLE;
          ready_nxt = 1'b1;
        end
      end
      ST_IDLE:
      begin
        ready_nxt = 1'b1;
        if (sample_valid)
        begin
          smp_nxt = sample_in;
          y_nxt = scale_factor;
          coef_nxt = coef;
          mode_nxt = decode_mode;
          rx_nxt = codeword_in;
          ready_nxt = 1'b0;
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        mem_raddr = tap_addr(3'h0, dqp_r, srp_r);
        tap_nxt = 3'h0;
        acc_nxt = 16'h0000;
        state_nxt = ST_TAP;
      end
      ST_TAP:
      begin
        // Tap order runs the six zeros before the two poles.
        mem_raddr = tap_addr(3'(tap_r + 3'h1), dqp_r, srp_r);
        if (tap_r <= `AQP_LAST_ZERO)
        begin
          prod = tap_mult(coef_r.zero[tap_r], aqp_float_t'(mem_rdata));
        end
        else
        begin
          prod = tap_mult(coef_r.pole[tap_r[0]], aqp_float_t'(mem_rdata));
        end
        sum = acc_r + prod;
        acc_nxt = sum;
        tap_nxt = 3'(tap_r + 3'h1);
        if (tap_r == `AQP_LAST_TAP)
        begin
          se_nxt = {sum[15], sum[15:1]};
          state_nxt = ST_DIFF;
        end
      end
      ST_DIFF:
      begin
        dif = {smp_r[15], smp_r} - {se_r[15], se_r};
        dabs = dif[16] ? -dif : dif;
        dm = (dabs > {2'b00, `AQP_MAG_MAX}) ? `AQP_MAG_MAX : dabs[14:0];
        lf = to_float(1'b0, dm);
        // The exponent is the index of the leading one and the leading one itself is dropped, so log of one is zero.
        le = (dm == 15'h0000) ? 4'h0 : 4'(lf.exp - 4'h1);
        lsh = {dm, 7'h00} >> le;
        dln_nxt = {1'b0, le, lsh[6:0]} - {1'b0, y_r[12:2]};
        neg_nxt = dif[16];
        q_nxt = 3'h0;
        state_nxt = mode_r ? ST_INVQ : ST_SEARCH;
      end
      ST_SEARCH:
      begin
        // One boundary per cycle keeps a single comparator at the cost of latency.
        if ((q_r < 3'(`AQP_NUM_BOUNDS)) && ($signed(dln_r) >= $signed(QB[q_r])))
        begin
          q_nxt = 3'(q_r + 3'h1);
        end
        else
        begin
          cw_nxt = (neg_r || (q_r == 3'h0)) ? ~{1'b0, q_r} : {1'b0, q_r};
          cwv_nxt = 1'b1;
          state_nxt = ST_INVQ;
        end
      end
      ST_INVQ:
      begin
        cwu = mode_r ? rx_r : cw_r;
        idx = cwu[3] ? ~cwu[2:0] : cwu[2:0];
        dqs_nxt = cwu[3];
        dql_nxt = IQ[idx][23:12] + {1'b0, y_r[12:2]};
        state_nxt = ST_ANTI;
      end
      ST_ANTI:
      begin
        am = {1'b1, dql_r[6:0]};
        if (dql_r[11])
        begin
          amag = 15'h0000;
        end
        else if (dql_r[10:7] > `AQP_MAX_EXP)
        begin
          amag = `AQP_MAG_MAX;
        end
        else
        begin
          amag = {am, 7'h00} >> 4'(`AQP_MAX_EXP - dql_r[10:7]);
        end
        dqm_nxt = amag;
        dq_nxt = dqs_r ? -{1'b0, amag} : {1'b0, amag};
        state_nxt = ST_RECON;
      end
      ST_RECON:
      begin
        sr_nxt = se_r + dq_r;
        dqp_nxt = (dqp_r == `AQP_LAST_ZERO) ? 3'h0 : 3'(dqp_r + 3'h1);
        mem_we = 1'b1;
        mem_waddr = dqp_nxt;
        mem_wdata = to_float(dqs_r, dqm_r);
        state_nxt = ST_STORE;
      end
      ST_STORE:
      begin
        srn = -sr_r;
        srp_nxt = ~srp_r;
        mem_we = 1'b1;
        mem_waddr = {2'b11, ~srp_r};
        mem_wdata = to_float(sr_r[15], sr_r[15] ? srn[14:0] : sr_r[14:0]);
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_INIT;
      tap_r <= 3'h0;
      dqp_r <= 3'h0;
      srp_r <= 1'b0;
      acc_r <= 16'h0000;
      smp_r <= 16'h0000;
      y_r <= 13'h0000;
      coef_r <= '0;
      mode_r <= 1'b0;
      rx_r <= 4'h0;
      neg_r <= 1'b0;
      dln_r <= 12'h000;
      q_r <= 3'h0;
      dql_r <= 12'h000;
      dqs_r <= 1'b0;
      dqm_r <= 15'h0000;
      ready_r <= 1'b0;
      cw_r <= 4'h0;
      cwv_r <= 1'b0;
      se_r <= 16'h0000;
      dq_r <= 16'h0000;
      sr_r <= 16'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tap_r <= tap_nxt;
      dqp_r <= dqp_nxt;
      srp_r <= srp_nxt;
      acc_r <= acc_nxt;
      smp_r <= smp_nxt;
      y_r <= y_nxt;
      coef_r <= coef_nxt;
      mode_r <= mode_nxt;
      rx_r <= rx_nxt;
      neg_r <= neg_nxt;
      dln_r <= dln_nxt;
      q_r <= q_nxt;
      dql_r <= dql_nxt;
      dqs_r <= dqs_nxt;
      dqm_r <= dqm_nxt;
      ready_r <= ready_nxt;
      cw_r <= cw_nxt;
      cwv_r <= cwv_nxt;
      se_r <= se_nxt;
      dq_r <= dq_nxt;
      sr_r <= sr_nxt;
      done_r <= done_nxt;
    end
  end

  assign sample_ready = ready_r;
  assign codeword_out = cw_r;
  assign codeword_valid = cwv_r;
  assign estimate_out = se_r;
  assign dq_out = dq_r;
  assign recon_out = sr_r;
  assign done = done_r;

endmodule
`default_nettype wire

// ===== include/aqp_regs.svh
// Constants of the ADPCM quantizer and predictor datapath.
`ifndef AQP_REGS_SVH
`define AQP_REGS_SVH

`define AQP_NUM_TAPS 8
`define AQP_NUM_ZEROS 6
`define AQP_NUM_BOUNDS 7
`define AQP_LAST_TAP 3'h7
`define AQP_LAST_ZERO 3'h5

// Region boundaries of the normalised log difference, 12-bit two's complement.
`define AQP_QB0 12'hF84
`define AQP_QB1 12'h050
`define AQP_QB2 12'h0B2
`define AQP_QB3 12'h0F6
`define AQP_QB4 12'h12C
`define AQP_QB5 12'h15D
`define AQP_QB6 12'h190

// Inverse level table, 24-bit words; the top 12 bits hold the log value.
`define AQP_IQ0 24'h800000
`define AQP_IQ1 24'h004000
`define AQP_IQ2 24'h087000
`define AQP_IQ3 24'h0D5000
`define AQP_IQ4 24'h111000
`define AQP_IQ5 24'h143000
`define AQP_IQ6 24'h175000
`define AQP_IQ7 24'h1A0000

`define AQP_ZERO_MANT 6'h20
`define AQP_MAX_EXP 4'hE
`define AQP_PP_EXP_BIAS 5'h1A
`define AQP_MAG_MAX 15'h7FFF

`endif

// ===== include/aqp_pkg.sv
// Types shared by the ADPCM quantizer and predictor datapath.
package aqp_pkg;

  typedef struct packed {
    logic sgn;
    logic [3:0] exp;
    logic [5:0] mant;
  } aqp_float_t;

  typedef struct packed {
    logic [1:0][15:0] pole;
    logic [5:0][15:0] zero;
  } aqp_coef_t;

  typedef enum logic [3:0] {
    ST_INIT,
    ST_IDLE,
    ST_FETCH,
    ST_TAP,
    ST_DIFF,
    ST_SEARCH,
    ST_INVQ,
    ST_ANTI,
    ST_RECON,
    ST_STORE
  } aqp_state_t;

endpackage

// ===== rtl/aqp_tap_mem.sv
// Delay-line store for the floating-point prediction data.
`timescale 1ns/100ps
`default_nettype none
module aqp_tap_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_r
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule
`default_nettype wire

// ===== sim/aqp_core_asserts.sv
// Concurrent checks on the ports of the quantizer and predictor core.
`timescale 1ns/100ps
`default_nettype none
module aqp_core_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic decode_mode,
  input wire logic sample_ready,
  input wire logic [3:0] codeword_out,
  input wire logic codeword_valid,
  input wire logic [15:0] estimate_out,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] recon_out,
  input wire logic done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = sample_ready && sample_valid;
  ////////////////////////////////////////////////////////////////////////////
  chk_take_busy: assert property (take |=> !sample_ready)
    else $error("ready stayed high after a take");
  chk_done_ready: assert property (done |-> sample_ready)
    else $error("done without ready");
  chk_init_busy: assert property ($rose(rst_n) |-> !sample_ready [*7])
    else $error("ready during delay clear");
  chk_cw_nonzero: assert property (codeword_valid |-> codeword_out != 4'h0)
    else $error("all-zero codeword sent");
  chk_cw_change: assert property ($changed(codeword_out) |-> codeword_valid)
    else $error("codeword changed without strobe");
  chk_enc_search: assert property (take && !decode_mode |-> ##[12:19] codeword_valid)
    else $error("no codeword after encode take");
  chk_dec_latency: assert property (take && decode_mode |=> (!done) [*8] ##1 (!done) [*6] ##1 done)
    else $error("decode done not at take plus 15");
  chk_dec_nocw: assert property (take && decode_mode |=> !codeword_valid until done)
    else $error("codeword strobe in decode");
  chk_cw_done: assert property (codeword_valid |-> ##4 done)
    else $error("done not four cycles after codeword");
  chk_recon_sum: assert property (done |-> recon_out == estimate_out + dq_out)
    else $error("recon is not estimate plus dq");
  cover property (take && decode_mode);
  cover property (codeword_valid && codeword_out == 4'hF);
  cover property (done && sample_valid);
endmodule
bind aqp_core aqp_core_asserts u_chk (.clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
  .decode_mode(decode_mode), .sample_ready(sample_ready), .codeword_out(codeword_out),
  .codeword_valid(codeword_valid), .estimate_out(estimate_out), .dq_out(dq_out),
  .recon_out(recon_out), .done(done));
`default_nettype wire

// ===== sim/aqp_partner.sv
// Sample source and receiving channel facing the quantizer core.
`timescale 1ns/100ps
`default_nettype none
module aqp_partner
(
  input wire logic clk,
  input wire logic sample_ready,
  input wire logic codeword_valid,
  input wire logic [3:0] codeword_out,
  output logic sample_valid,
  output logic [15:0] sample_in,
  output logic decode_mode,
  output logic [3:0] codeword_in,
  output logic [12:0] scale_factor
);
  logic [3:0] rx_q[$];
  initial
  begin
    sample_valid = 1'h0;
    sample_in = 16'h0000;
    decode_mode = 1'h0;
    codeword_in = 4'h0;
    scale_factor = 13'h0000;
  end
  // Held until an edge sees ready; released fields show their inverse so stale data cannot pass.
  // Ready is read settled after an edge, which is the value that the core samples at the next edge.
  task automatic send(input logic dec, input logic [15:0] s, input logic [3:0] cw, input logic [12:0] y);
    logic hit;
    @(posedge clk);
    #1;
    sample_valid = 1'h1;
    sample_in = s;
    decode_mode = dec;
    codeword_in = cw;
    scale_factor = y;
    hit = (sample_ready === 1'h1);
    @(posedge clk);
    while (!hit)
    begin
      #1;
      hit = (sample_ready === 1'h1);
      @(posedge clk);
    end
    #1;
    sample_valid = 1'h0;
    sample_in = ~s;
    decode_mode = ~dec;
    codeword_in = ~cw;
    scale_factor = ~y;
  endtask
  // The strobe is sampled mid-cycle, where it stands settled.
  always @(negedge clk)
  begin
    if (codeword_valid === 1'h1)
      rx_q.push_back(codeword_out);
  end
endmodule
`default_nettype wire

// ===== sim/adpcm_quantizer_predictor_bench.sv
// Self-checking bench of the quantizer and predictor core.
`timescale 1ns/100ps
`default_nettype none
module adpcm_quantizer_predictor_bench;
  import aqp_pkg::*;
  typedef struct packed {
    logic dec;
    logic [15:0] s;
    logic [3:0] cwi;
    logic [12:0] y;
    logic [3:0] cw;
    logic [15:0] dq;
  } aqp_row_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  aqp_coef_t coef = '0;
  logic sample_valid, decode_mode, sample_ready, codeword_valid, done;
  logic [15:0] sample_in, estimate_out, dq_out, recon_out;
  logic [3:0] codeword_in, codeword_out;
  logic [12:0] scale_factor;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  aqp_row_t rows [0:20];
  always #50 clk = ~clk;
  aqp_core DUT (.clk(clk), .rst_n(rst_n), .sample_valid(sample_valid), .sample_in(sample_in),
    .decode_mode(decode_mode), .codeword_in(codeword_in), .scale_factor(scale_factor), .coef(coef),
    .sample_ready(sample_ready), .codeword_out(codeword_out), .codeword_valid(codeword_valid),
    .estimate_out(estimate_out), .dq_out(dq_out), .recon_out(recon_out), .done(done));
  aqp_partner PM (.clk(clk), .sample_ready(sample_ready), .codeword_valid(codeword_valid),
    .codeword_out(codeword_out), .sample_valid(sample_valid), .sample_in(sample_in),
    .decode_mode(decode_mode), .codeword_in(codeword_in), .scale_factor(scale_factor));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_cw(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while ((done !== 1'h1) && (n < 40))
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'h1)
    begin
      $display("Error at %0t: done got %h expected %h", $time, done, 1'h1);
      fail_count++;
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // The whole run needs well under two thousand cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{'{1'h0, 16'h0001, 4'h0, 13'h0000, 4'h1, 16'h0000}, '{1'h0, 16'h0002, 4'h0, 13'h0000, 4'h2, 16'h0000},
      '{1'h0, 16'h0003, 4'h0, 13'h0000, 4'h3, 16'h0000}, '{1'h0, 16'h0005, 4'h0, 13'h0000, 4'h4, 16'h0000},
      '{1'h0, 16'h0006, 4'h0, 13'h0000, 4'h5, 16'h0000}, '{1'h0, 16'h0007, 4'h0, 13'h0000, 4'h6, 16'h0000},
      '{1'h0, 16'h7FFF, 4'h0, 13'h0000, 4'h7, 16'h0000}, '{1'h0, 16'hFFFF, 4'h0, 13'h0000, 4'hE, 16'h0000},
      '{1'h0, 16'h8001, 4'h0, 13'h0000, 4'h8, 16'h0000}, '{1'h0, 16'h0001, 4'h0, 13'h1000, 4'hF, 16'h0000},
      '{1'h1, 16'h0000, 4'h0, 13'h0000, 4'h0, 16'h0000}, '{1'h1, 16'h0000, 4'h1, 13'h0000, 4'h0, 16'h0001},
      '{1'h1, 16'h0000, 4'h2, 13'h0000, 4'h0, 16'h0002}, '{1'h1, 16'h0000, 4'h3, 13'h0000, 4'h0, 16'h0003},
      '{1'h1, 16'h0000, 4'h4, 13'h0000, 4'h0, 16'h0004}, '{1'h1, 16'h0000, 4'h5, 13'h0000, 4'h0, 16'h0006},
      '{1'h1, 16'h0000, 4'h6, 13'h0000, 4'h0, 16'h0007}, '{1'h1, 16'h0000, 4'h7, 13'h0000, 4'h0, 16'h000A},
      '{1'h1, 16'h0000, 4'h8, 13'h0000, 4'h0, 16'hFFF6}, '{1'h1, 16'h0000, 4'hF, 13'h0000, 4'h0, 16'h0000},
      '{1'h1, 16'h0000, 4'h7, 13'h0200, 4'h0, 16'h0014}};
    repeat (16) @(posedge clk);
    #1;
    cmp_word({15'h0000, sample_ready}, 16'h0000);
    rst_n = 1'h1;
    // Cleared delay data keep a leading one, so a large coefficient gives one per tap and eight halve to four.
    coef = {8{16'h7FFF}};
    PM.send(1'h0, 16'h0001, 4'h0, 13'h0000);
    wait_done();
    cmp_word(estimate_out, 16'h0004);
    coef = '0;
    for (int i = 0; i < 21; i++)
    begin
      PM.send(rows[i].dec, rows[i].s, rows[i].cwi, rows[i].y);
      wait_done();
      if (rows[i].dec) cmp_word(recon_out, rows[i].dq);
      else cmp_cw(codeword_out, rows[i].cw);
    end
    // Second sample is offered while the first is still busy and must wait.
    PM.rx_q.delete();
    PM.send(1'h0, 16'hFFFF, 4'h0, 13'h0000);
    PM.send(1'h0, 16'h0001, 4'h0, 13'h1000);
    wait_done();
    cmp_word(16'(PM.rx_q.size()), 16'h0002);
    cmp_cw(PM.rx_q[0], 4'hE);
    cmp_cw(PM.rx_q[1], 4'hF);
    cmp_word(dq_out, 16'h0000);
    // Reset in mid-sample clears the outputs and the delay line.
    coef = {8{16'h4000}};
    PM.send(1'h0, 16'h7FFF, 4'h0, 13'h0000);
    rst_n = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'h1;
    cmp_word({15'h0000, sample_ready}, 16'h0000);
    cmp_word(dq_out, 16'h0000);
    PM.send(1'h0, 16'h0002, 4'h0, 13'h0000);
    wait_done();
    cmp_word(estimate_out, 16'h0004);
    cmp_cw(codeword_out, 4'hD);
    tally_and_finish();
  end
endmodule
`default_nettype wire
